// ---- dv/tsd_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsd_cpu_model
  import tsd_pkg::*;
(
  input  wire logic             clk,
  output logic                  cyc,
  output logic                  stb,
  output logic                  we,
  output logic      [ADR_W-1:0] adr,
  output logic      [3:0]       sel,
  output logic      [31:0]      dat_w,
  input  wire logic [31:0]      dat_r,
  input  wire logic             ack
);
  // bus idle from time zero
  initial begin
    {cyc, stb, we, sel} <= '0;
    adr <= '0;
    dat_w <= '0;
  end
  // one classic cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    {cyc, stb, we} <= {2'b11, w};
    adr <= {i, 2'b00};
    sel <= 4'h1;
    dat_w <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_r[7:0];
    {cyc, stb, we} <= 3'b000;
    adr <= ~adr; // stale lines do not keep the last value
    dat_w <= ~dat_w;
  endtask : xfer
  // word write, high byte parked first
  task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
    logic [7:0] q;
    xfer(1'b1, lo + 8'h01, v[15:8], q);
    xfer(1'b1, lo, v[7:0], q);
  endtask : wr16
  // word read, low byte first latches the high byte
  task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
    xfer(1'b0, lo, 8'h00, v[7:0]);
    xfer(1'b0, lo + 8'h01, 8'h00, v[15:8]);
  endtask : rd16
endmodule : tsd_cpu_model
`default_nettype wire

// ---- dv/tsd_timer_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsd_timer_bench
  import tsd_pkg::*;
;
  localparam logic [7:0] PAIRS [4] = '{IDX_COUNT_LOW, IDX_CAPT_LOW, IDX_CMPA_LOW, IDX_CMPB_LOW};
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             cyc, stb, we, ack, tick, capt;
  logic [ADR_W-1:0] adr;
  logic [3:0]       sel;
  logic [31:0]      dw, dr;
  logic [5:0]       flg;
  logic [1:0]       mt, wv;
  logic [15:0]      c, v;
  logic [7:0]       q, s;
  int               bad_count = 0, comparisons = 0, cycles = 0, na = 0, nb = 0, na0 = 0, nb0 = 0;
  tsd_timer tsd_timer_i (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .timer_tick(tick),
    .capture_trigger(capt), .comparator0_event_flag(flg[0]), .comparator1_event_flag(flg[1]),
    .ext_irq1_flag(flg[2]), .pin_change1_flag(flg[3]), .timer2_overflow_flag(flg[4]),
    .timer0_overflow_flag(flg[5]), .match_a(mt[0]), .match_b(mt[1]), .wave_out_a(wv[0]),
    .wave_out_b(wv[1])
  );
  tsd_cpu_model tsd_cpu_model_i (
    .clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat_w(dw), .dat_r(dr), .ack(ack)
  );
  // clock, match pulse counts and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) begin
    na <= na + int'(mt[0]);
    nb <= nb + int'(mt[1]);
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count = bad_count + 1;
      finish_test();
    end
  end
  function automatic logic [7:0] sbit(input int j);
    return 8'h01 << (j < 2 ? j : j + 2);
  endfunction : sbit
  function automatic logic [15:0] shut_exp(input int j);
    return 16'h3 ^ (16'h1 << (j % 2));
  endfunction : shut_exp
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  // bus shorthands
  task automatic w(input logic [7:0] i, input logic [7:0] d);
    tsd_cpu_model_i.xfer(1'b1, i, d, q);
  endtask : w
  task automatic r(input logic [7:0] i);
    tsd_cpu_model_i.xfer(1'b0, i, 8'h00, q);
  endtask : r
  task automatic w16(input logic [7:0] i, input logic [15:0] d);
    tsd_cpu_model_i.wr16(i, d);
  endtask : w16
  task automatic r16(input logic [7:0] i);
    tsd_cpu_model_i.rd16(i, v);
  endtask : r16
  // timer clock pulses, then room for the match pulse
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
    end
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : ticks
  task automatic pulse(input int j);
    @(posedge clk) flg[j] <= 1'b1;
    @(posedge clk) flg[j] <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : pulse
  initial begin
    {tick, capt, flg} <= '0;
    void'($urandom(24));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // reset values, plus one spare index
    for (int i = 8'h80; i <= 8'h8c; i++) begin
      r(8'(i));
      chk("reset byte", 16'h0, {8'h0, q});
    end
    $display("test reset done");
    // random round trips while stopped
    repeat (6) begin
      foreach (PAIRS[k]) begin
        c = 16'($urandom);
        w16(PAIRS[k], c);
        r16(PAIRS[k]);
        chk("word", c, v);
      end
      s = 8'($urandom);
      w(IDX_SHUT_ENABLE, s);
      r(IDX_SHUT_ENABLE);
      chk("enable", {8'h0, s & 8'h30}, {8'h0, q});
      w(IDX_SRC_SELECT, s);
      r(IDX_SRC_SELECT);
      chk("select", {8'h0, s & SRC_MASK}, {8'h0, q});
    end
    w(8'h10, 8'hff);
    r(8'h10);
    chk("unmapped", 16'h0, {8'h0, q});
    $display("test registers done");
    // count write hides one match, then a and b match in turn
    c = 16'h0010 + 16'($urandom_range(32'hfe00));
    w(IDX_MODE_CTRL, 8'h10);
    w16(IDX_CMPA_LOW, c);
    w16(IDX_CMPB_LOW, c + 16'h1);
    w16(IDX_COUNT_LOW, c);
    @(negedge clk) na0 = na;
    ticks(1);
    chk("blocked", 16'h0, 16'(na - na0));
    w16(IDX_COUNT_LOW, c - 16'h2);
    @(negedge clk) nb0 = nb;
    ticks(4);
    chk("match a", 16'h1, 16'(na - na0));
    chk("match b", 16'h1, 16'(nb - nb0));
    @(posedge clk) capt <= 1'b1;
    @(posedge clk) capt <= 1'b0;
    r16(IDX_CAPT_LOW);
    chk("capture", c + 16'h2, v);
    w(IDX_MODE_CTRL, 8'h00);
    ticks(3);
    r16(IDX_COUNT_LOW);
    chk("held", c + 16'h2, v);
    // capture serving as top ignores the trigger
    w16(IDX_COUNT_LOW, c);
    w(IDX_MODE_CTRL, {4'h0, MODE_CTC_CAPT});
    @(posedge clk) capt <= 1'b1;
    @(posedge clk) capt <= 1'b0;
    r16(IDX_CAPT_LOW);
    chk("capture top", c + 16'h2, v);
    $display("test counting done");
    // pwm: compare write waits in the buffer until bottom
    w16(IDX_CMPA_LOW, 16'h0080);
    w(IDX_MODE_CTRL, {4'h1, MODE_FAST8});
    w16(IDX_CMPA_LOW, 16'h0010);
    r16(IDX_CMPA_LOW);
    chk("buffer", 16'h0010, v);
    w16(IDX_COUNT_LOW, 16'h0008);
    @(negedge clk) na0 = na;
    ticks(10);
    w16(IDX_COUNT_LOW, 16'h00fe);
    ticks(20);
    chk("pwm match", 16'h1, 16'(na - na0));
    $display("test buffering done");
    // shutdown sources, enables and latch release
    w(IDX_MODE_CTRL, 8'h10);
    w16(IDX_CMPA_LOW, 16'h8000);
    w16(IDX_CMPB_LOW, 16'h8000);
    w16(IDX_COUNT_LOW, 16'hffff);
    ticks(2);
    chk("wave", 16'h3, {14'h0, wv});
    for (int j = 0; j < 6; j++) begin
      w(IDX_SHUT_ENABLE, 8'h00);
      w(IDX_SRC_SELECT, sbit(j));
      pulse(j);
      chk("enable off", 16'h3, {14'h0, wv});
      w(IDX_SHUT_ENABLE, 8'h10 << (j % 2));
      w(IDX_SRC_SELECT, SRC_MASK ^ sbit(j));
      pulse(j);
      chk("other source", 16'h3, {14'h0, wv});
      w(IDX_SRC_SELECT, sbit(j));
      pulse(j);
      chk("shut", shut_exp(j), {14'h0, wv});
      w(IDX_SHUT_STATUS, 8'h03);
      repeat (2) @(negedge clk);
      chk("released", 16'h3, {14'h0, wv});
    end
    w(IDX_SHUT_ENABLE, 8'h30);
    w(IDX_SRC_SELECT, SRC_MASK);
    pulse(5);
    chk("any source", 16'h0, {14'h0, wv});
    $display("test shutdown done");
    finish_test();
  end
endmodule : tsd_timer_bench
`default_nettype wire

// ---- dv/tsd_timer_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsd_timer_props
  import tsd_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             timer_tick,
  input wire logic             comparator0_event_flag,
  input wire logic             comparator1_event_flag,
  input wire logic             ext_irq1_flag,
  input wire logic             pin_change1_flag,
  input wire logic             timer2_overflow_flag,
  input wire logic             timer0_overflow_flag,
  input wire logic             match_a,
  input wire logic             match_b,
  input wire logic             wave_out_a,
  input wire logic             wave_out_b
);
  logic [1:0] en_reg;
  logic [7:0] src_reg;
  logic       blk_reg;
  logic       take_wr;
  logic [7:0] idx;
  logic [7:0] fmap;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // taken writes and flags in select-bit order
  assign take_wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[9:2];
  assign fmap = {timer0_overflow_flag, timer2_overflow_flag, pin_change1_flag, ext_irq1_flag,
                 2'b00, comparator1_event_flag, comparator0_event_flag};
  // shadow of shutdown controls and the post-write match block
  always_ff @(posedge clk) begin
    if (rst) begin
      en_reg <= 2'b00;
      src_reg <= 8'h00;
      blk_reg <= 1'b0;
    end else begin
      if (take_wr && idx == IDX_SHUT_ENABLE) en_reg <= wb_dat_i[5:4];
      if (take_wr && idx == IDX_SRC_SELECT) src_reg <= wb_dat_i[7:0];
      if (take_wr && idx == IDX_COUNT_LOW) blk_reg <= 1'b1;
      else if (timer_tick) blk_reg <= 1'b0;
    end
  end
  property p_ack_follows; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("request not answered next cycle");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held past one cycle");
  property p_unmapped; wb_ack_o && !$past(wb_we_i) && ($past(idx) < IDX_SHUT_STATUS
    || $past(idx) > IDX_CMPB_HIGH) |-> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_en_bits; wb_ack_o && !$past(wb_we_i) && $past(idx) == IDX_SHUT_ENABLE
    |-> (wb_dat_o & ~32'h30) == 32'h0; endproperty
  a_en_bits: assert property (p_en_bits) else $error("enable read has stray bits");
  property p_shut_a; en_reg[0] && |(src_reg & fmap & ~$past(fmap)) |-> ##1 !wave_out_a; endproperty
  a_shut_a: assert property (p_shut_a) else $error("channel a not shut");
  property p_shut_b; en_reg[1] && |(src_reg & fmap & ~$past(fmap)) |-> ##1 !wave_out_b; endproperty
  a_shut_b: assert property (p_shut_b) else $error("channel b not shut");
  property p_match_tick; match_a || match_b |-> $past(timer_tick); endproperty
  a_match_tick: assert property (p_match_tick) else $error("match without tick");
  property p_match_block; match_a || match_b |-> !$past(blk_reg); endproperty
  a_match_block: assert property (p_match_block) else $error("match after count write");
  c_match_a: cover property (match_a);
  c_match_b: cover property (match_b);
  c_shut: cover property (en_reg[0] && $fell(wave_out_a));
endmodule : tsd_timer_props
bind tsd_timer tsd_timer_props tsd_timer_props_i (
  .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .timer_tick, .comparator0_event_flag, .comparator1_event_flag, .ext_irq1_flag,
  .pin_change1_flag, .timer2_overflow_flag, .timer0_overflow_flag, .match_a, .match_b,
  .wave_out_a, .wave_out_b
);
`default_nettype wire

// ---- pkg/tsd_pkg.sv ----
`default_nettype none
package tsd_pkg;

  // bus geometry
  localparam int unsigned ADR_W = 10;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_SHUT_STATUS = 8'h80;
  localparam logic [7:0] IDX_MODE_CTRL   = 8'h81;
  localparam logic [7:0] IDX_SHUT_ENABLE = 8'h82;
  localparam logic [7:0] IDX_SRC_SELECT  = 8'h83;
  localparam logic [7:0] IDX_COUNT_LOW   = 8'h84;
  localparam logic [7:0] IDX_COUNT_HIGH  = 8'h85;
  localparam logic [7:0] IDX_CAPT_LOW    = 8'h86;
  localparam logic [7:0] IDX_CAPT_HIGH   = 8'h87;
  localparam logic [7:0] IDX_CMPA_LOW    = 8'h88;
  localparam logic [7:0] IDX_CMPA_HIGH   = 8'h89;
  localparam logic [7:0] IDX_CMPB_LOW    = 8'h8a;
  localparam logic [7:0] IDX_CMPB_HIGH   = 8'h8b;

  // field positions
  localparam int unsigned MODE_LSB      = 0;
  localparam int unsigned RUN_BIT       = 4;
  localparam int unsigned SHUT_EN_A_BIT = 4;
  localparam int unsigned SHUT_EN_B_BIT = 5;
  localparam logic [7:0]  SRC_MASK      = 8'hf3;

  // values after reset
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0]  RST_MODE = 4'h0;

  // fixed counting tops
  localparam logic [15:0] TOP_8BIT  = 16'h00ff;
  localparam logic [15:0] TOP_9BIT  = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] TOP_MAX   = 16'hffff;
  localparam logic [15:0] BOTTOM    = 16'h0000;

  // counting mode codes
  localparam logic [3:0] MODE_NORMAL     = 4'h0;
  localparam logic [3:0] MODE_PC8        = 4'h1;
  localparam logic [3:0] MODE_PC9        = 4'h2;
  localparam logic [3:0] MODE_PC10       = 4'h3;
  localparam logic [3:0] MODE_CTC_CMPA   = 4'h4;
  localparam logic [3:0] MODE_FAST8      = 4'h5;
  localparam logic [3:0] MODE_FAST9      = 4'h6;
  localparam logic [3:0] MODE_FAST10     = 4'h7;
  localparam logic [3:0] MODE_PFC_CAPT   = 4'h8;
  localparam logic [3:0] MODE_PFC_CMPA   = 4'h9;
  localparam logic [3:0] MODE_PC_CAPT    = 4'ha;
  localparam logic [3:0] MODE_PC_CMPA    = 4'hb;
  localparam logic [3:0] MODE_CTC_CAPT   = 4'hc;
  localparam logic [3:0] MODE_RESERVED   = 4'hd;
  localparam logic [3:0] MODE_FAST_CAPT  = 4'he;
  localparam logic [3:0] MODE_FAST_CMPA  = 4'hf;

endpackage : tsd_pkg
`default_nettype wire

// ---- rtl/tsd_compare_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsd_compare_channel
  import tsd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        buffered,
  input  wire logic        load_evt,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic [15:0] count,
  input  wire logic        eval_en,
  input  wire logic        period_start,
  input  wire logic        shutdown_enable,
  input  wire logic        trigger,
  input  wire logic        clear_shutdown,
  output logic      [15:0] active_value,
  output logic      [15:0] cpu_value,
  output logic             match,
  output logic             wave_out,
  output logic             shut_flag
);

  typedef struct packed {
    logic [15:0] active;
    logic [15:0] buffer;
    logic        match;
    logic        wave;
    logic        wave_out;
    logic        shut;
  } tsd_chan_state_t;

  tsd_chan_state_t state_reg;
  tsd_chan_state_t state_next;
  logic            hit;

  // next state of one compare channel
  always_comb begin
    state_next = state_reg;
    hit = eval_en && (count == state_reg.active);
    if (wr_en) begin
      state_next.buffer = wr_data;
      if (!buffered) begin
        state_next.active = wr_data;
      end
    end
    if (buffered && load_evt) begin
      state_next.active = state_reg.buffer;
    end
    state_next.match = hit;
    if (hit) begin
      state_next.wave = 1'b0;
    end else if (period_start) begin
      state_next.wave = 1'b1;
    end
    // set wins over software clear
    if (trigger && shutdown_enable) begin
      state_next.shut = 1'b1;
    end else if (clear_shutdown) begin
      state_next.shut = 1'b0;
    end
    state_next.wave_out = state_next.wave && !state_next.shut;
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign active_value = state_reg.active;
  assign cpu_value    = buffered ? state_reg.buffer : state_reg.active;
  assign match        = state_reg.match;
  assign wave_out     = state_reg.wave_out;
  assign shut_flag    = state_reg.shut;

endmodule : tsd_compare_channel
`default_nettype wire

// ---- rtl/tsd_timer.sv ----
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - enable clear: triggers never stop the output
// - select bit 0: comparator 0 edge stops output
// - select bit 1: comparator 1 edge stops output
// - select bit 4: external irq 1 edge stops
// - select bit 5: pin change 1 edge stops
// - select bit 6: timer two overflow stops
// - select bit 7: timer zero overflow stops
// - any selected source edge triggers shutdown
// - counter write blocks next timer-clock match
// - written count skipping compare loses match
// - no clock source: counter holds, stays accessible
// - processor write beats clear or count
// - capture trigger copies counter into capture unless capture is top
// - some modes use capture as top
// - compare equals counter gives a match
// - compare double buffered in pwm modes
// - normal and ctc modes write directly
// - buffer loads only at top or bottom
// - processor reaches buffer when double buffered
// - enable set: selected trigger stops output
module tsd_timer
  import tsd_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             timer_tick,
  input  wire logic             capture_trigger,
  input  wire logic             comparator0_event_flag,
  input  wire logic             comparator1_event_flag,
  input  wire logic             ext_irq1_flag,
  input  wire logic             pin_change1_flag,
  input  wire logic             timer2_overflow_flag,
  input  wire logic             timer0_overflow_flag,
  output logic                  match_a,
  output logic                  match_b,
  output logic                  wave_out_a,
  output logic                  wave_out_b
);

  typedef struct packed {
    logic [15:0] count;
    logic        down;
    logic [7:0]  temp;
    logic [15:0] capture;
    logic [3:0]  mode;
    logic        run;
    logic [1:0]  shutdown_enable;
    logic [7:0]  shutdown_source_select;
    logic [7:0]  flag_prev;
    logic        block;
    logic        ack;
    logic [7:0]  rdata;
  } tsd_state_t;

  tsd_state_t state_reg;
  tsd_state_t state_next;

  logic [7:0]  idx;
  logic        req;
  logic        wr;
  logic        rd;
  logic [7:0]  wbyte;
  logic [7:0]  flags;
  logic        trigger;
  logic        step;
  logic        phase_correct;
  logic        capt_is_top;
  logic        buffered;
  logic        load_at_top;
  logic [15:0] top;
  logic        at_top;
  logic        at_bottom;
  logic        load_evt;
  logic        eval_en;
  logic [15:0] paired;
  logic        wr_cmp_a;
  logic        wr_cmp_b;
  logic [1:0]  clear_shut;
  logic [15:0] cmp_a_active;
  logic [15:0] cmp_a_cpu;
  logic [15:0] cmp_b_cpu;
  logic [1:0]  shut_flags;
  logic [1:0]  match_w;
  logic [1:0]  wave_w;

  // bus request decode, one access per ack
  assign req   = wb_cyc_i && wb_stb_i && !state_reg.ack;
  assign wr    = req && wb_we_i && wb_sel_i[0];
  assign rd    = req && !wb_we_i;
  assign idx   = wb_adr_i[ADR_W-1:2];
  assign wbyte = wb_dat_i[7:0];

  // low byte write pairs with the held high byte
  assign paired = {state_reg.temp, wbyte};

  // event flags in select-bit order, bits 3:2 unused
  assign flags = {timer0_overflow_flag,
                  timer2_overflow_flag,
                  pin_change1_flag,
                  ext_irq1_flag,
                  2'b00,
                  comparator1_event_flag,
                  comparator0_event_flag};

  // rising edge on any selected flag
  assign trigger = |(flags & ~state_reg.flag_prev
                     & state_reg.shutdown_source_select);

  // timer clock only counts with a clock source
  assign step = timer_tick && state_reg.run;

  // mode properties
  always_comb begin
    phase_correct = 1'b0;
    capt_is_top   = 1'b0;
    buffered      = 1'b1;
    load_at_top   = 1'b0;
    top           = TOP_MAX;
    unique case (state_reg.mode)
      MODE_NORMAL: begin
        buffered = 1'b0;
      end
      MODE_PC8: begin
        phase_correct = 1'b1;
        load_at_top   = 1'b1;
        top           = TOP_8BIT;
      end
      MODE_PC9: begin
        phase_correct = 1'b1;
        load_at_top   = 1'b1;
        top           = TOP_9BIT;
      end
      MODE_PC10: begin
        phase_correct = 1'b1;
        load_at_top   = 1'b1;
        top           = TOP_10BIT;
      end
      MODE_CTC_CMPA: begin
        buffered = 1'b0;
        top      = cmp_a_active;
      end
      MODE_FAST8: begin
        top = TOP_8BIT;
      end
      MODE_FAST9: begin
        top = TOP_9BIT;
      end
      MODE_FAST10: begin
        top = TOP_10BIT;
      end
      MODE_PFC_CAPT: begin
        phase_correct = 1'b1;
        capt_is_top   = 1'b1;
        top           = state_reg.capture;
      end
      MODE_PFC_CMPA: begin
        phase_correct = 1'b1;
        top           = cmp_a_active;
      end
      MODE_PC_CAPT: begin
        phase_correct = 1'b1;
        capt_is_top   = 1'b1;
        load_at_top   = 1'b1;
        top           = state_reg.capture;
      end
      MODE_PC_CMPA: begin
        phase_correct = 1'b1;
        load_at_top   = 1'b1;
        top           = cmp_a_active;
      end
      MODE_CTC_CAPT: begin
        buffered    = 1'b0;
        capt_is_top = 1'b1;
        top         = state_reg.capture;
      end
      MODE_RESERVED: begin
        buffered = 1'b0;
      end
      MODE_FAST_CAPT: begin
        capt_is_top = 1'b1;
        load_at_top = 1'b1;
        top         = state_reg.capture;
      end
      MODE_FAST_CMPA: begin
        load_at_top = 1'b1;
        top         = cmp_a_active;
      end
    endcase
  end

  // update points of the counting sequence
  assign at_top    = step && (state_reg.count == top);
  assign at_bottom = step && (state_reg.count == BOTTOM);
  assign load_evt  = load_at_top ? at_top : at_bottom;

  // matches are blocked on the tick after a count write
  assign eval_en = step && !state_reg.block;

  // compare register writes and shutdown clears
  assign wr_cmp_a   = wr && (idx == IDX_CMPA_LOW);
  assign wr_cmp_b   = wr && (idx == IDX_CMPB_LOW);
  assign clear_shut = (wr && (idx == IDX_SHUT_STATUS)) ? wbyte[1:0] : 2'b00;

  // main next-state logic
  always_comb begin
    state_next           = state_reg;
    state_next.flag_prev = flags;
    state_next.ack       = req;
    // counting, overridden below by a processor write
    if (step) begin
      state_next.block = 1'b0;
      if (phase_correct) begin
        if (!state_reg.down) begin
          if (state_reg.count >= top) begin
            state_next.down  = 1'b1;
            state_next.count = state_reg.count - 16'h0001;
          end else begin
            state_next.count = state_reg.count + 16'h0001;
          end
        end else begin
          if (state_reg.count == BOTTOM) begin
            state_next.down  = 1'b0;
            state_next.count = state_reg.count + 16'h0001;
          end else begin
            state_next.count = state_reg.count - 16'h0001;
          end
        end
      end else begin
        state_next.down = 1'b0;
        if (state_reg.count == top) begin
          state_next.count = BOTTOM;
        end else begin
          state_next.count = state_reg.count + 16'h0001;
        end
      end
    end
    // capture unless the capture register serves as top
    if (capture_trigger && !capt_is_top) begin
      state_next.capture = state_reg.count;
    end
    // processor writes
    if (wr) begin
      unique case (idx)
        IDX_MODE_CTRL: begin
          state_next.mode = wbyte[MODE_LSB +: 4];
          state_next.run  = wbyte[RUN_BIT];
        end
        IDX_SHUT_ENABLE: begin
          state_next.shutdown_enable = {wbyte[SHUT_EN_B_BIT], wbyte[SHUT_EN_A_BIT]};
        end
        IDX_SRC_SELECT: begin
          state_next.shutdown_source_select = wbyte & SRC_MASK;
        end
        IDX_COUNT_LOW: begin
          state_next.count = paired;
          state_next.block = 1'b1;
        end
        IDX_CAPT_LOW: begin
          state_next.capture = paired;
        end
        IDX_COUNT_HIGH, IDX_CAPT_HIGH, IDX_CMPA_HIGH, IDX_CMPB_HIGH: begin
          state_next.temp = wbyte;
        end
        default: begin
        end
      endcase
    end
    // processor reads, low byte latches the high byte
    state_next.rdata = RST_BYTE;
    if (rd) begin
      unique case (idx)
        IDX_SHUT_STATUS: begin
          state_next.rdata = {6'b000000, shut_flags};
        end
        IDX_MODE_CTRL: begin
          state_next.rdata = {3'b000, state_reg.run, state_reg.mode};
        end
        IDX_SHUT_ENABLE: begin
          state_next.rdata = {2'b00, state_reg.shutdown_enable, 4'h0};
        end
        IDX_SRC_SELECT: begin
          state_next.rdata = state_reg.shutdown_source_select;
        end
        IDX_COUNT_LOW: begin
          state_next.rdata = state_reg.count[7:0];
          state_next.temp  = state_reg.count[15:8];
        end
        IDX_CAPT_LOW: begin
          state_next.rdata = state_reg.capture[7:0];
          state_next.temp  = state_reg.capture[15:8];
        end
        IDX_CMPA_LOW: begin
          state_next.rdata = cmp_a_cpu[7:0];
          state_next.temp  = cmp_a_cpu[15:8];
        end
        IDX_CMPB_LOW: begin
          state_next.rdata = cmp_b_cpu[7:0];
          state_next.temp  = cmp_b_cpu[15:8];
        end
        IDX_COUNT_HIGH, IDX_CAPT_HIGH, IDX_CMPA_HIGH, IDX_CMPB_HIGH: begin
          state_next.rdata = state_reg.temp;
        end
        default: begin
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // one channel per compare register
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      logic [15:0] act_w;
      logic [15:0] cpu_w;
      tsd_compare_channel u_chan (
        .clk             (clk),
        .rst             (rst),
        .buffered        (buffered),
        .load_evt        (load_evt),
        .wr_en           ((ch == 0) ? wr_cmp_a : wr_cmp_b),
        .wr_data         (paired),
        .count           (state_reg.count),
        .eval_en         (eval_en),
        .period_start    (at_bottom),
        .shutdown_enable (state_reg.shutdown_enable[ch]),
        .trigger         (trigger),
        .clear_shutdown  (clear_shut[ch]),
        .active_value    (act_w),
        .cpu_value       (cpu_w),
        .match           (match_w[ch]),
        .wave_out        (wave_w[ch]),
        .shut_flag       (shut_flags[ch])
      );
      if (ch == 0) begin : g_a
        assign cmp_a_active = act_w;
        assign cmp_a_cpu    = cpu_w;
      end else begin : g_b
        assign cmp_b_cpu = cpu_w;
      end
    end
  endgenerate

  // outputs, all from flip-flops
  assign wb_dat_o   = {24'h000000, state_reg.rdata};
  assign wb_ack_o   = state_reg.ack;
  assign match_a    = match_w[0];
  assign match_b    = match_w[1];
  assign wave_out_a = wave_w[0];
  assign wave_out_b = wave_w[1];

endmodule : tsd_timer
`default_nettype wire
